// ---- logic/sttx_pkg.sv ----
// Shared constants and types of the serial transmitter mode and clock block
package sttx_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_PERIOD = 12'h008;

    // Control fields and reset value
    localparam int CTRL_WIDE_BIT = 0;
    localparam int CTRL_DOUBLE_BIT = 1;
    localparam int CTRL_EXTCLK_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Status fields
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_LOCKED_BIT = 1;
    localparam int STAT_EXTCLK_BIT = 2;

    // ****************************************************************
    // Frame layout
    // ****************************************************************
    localparam int FRAME_MAX = 24;
    localparam logic [4:0] FRAME_LEN_WIDE = 5'h18;
    localparam logic [4:0] FRAME_LEN_NARROW = 5'h14;
    localparam logic [3:0] HDR_DATA = 4'hd;
    localparam logic [3:0] HDR_CTRL = 4'hb;
    localparam logic [3:0] HDR_FILL = 4'hc;
    localparam logic [19:0] FILL_DATA = 20'ha5a5a;

    // ****************************************************************
    // Clock multiplier
    // ****************************************************************
    localparam int PERIOD_W = 16;
    localparam logic [3:0] LOCK_PERIODS = 4'h4;

    typedef enum logic [1:0] {FK_FILL, FK_DATA, FK_CTRL} sttx_frame_kind_t;

endpackage

// ---- logic/sttx_rate_mult.sv ----
// Period-measuring clock multiplier producing evenly spaced tick pulses
`timescale 1ns/10ps
module sttx_rate_mult
    import sttx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ref_tick,
    input wire logic [5:0] mult,
    output logic out_tick,
    output logic locked,
    output logic [sttx_pkg::PERIOD_W-1:0] period
);
    logic [PERIOD_W-1:0] cnt_q, cnt_d, period_q, period_d;
    logic [PERIOD_W:0] acc_q, acc_d, acc_sum;
    logic [3:0] stable_q, stable_d;
    logic tick_q, tick_d;

    // ****************************************************************
    // Period measure, lock detect and tick spreading
    // ****************************************************************
    always_comb
    begin
        cnt_d = (cnt_q == {PERIOD_W{1'b1}}) ? cnt_q : cnt_q + 16'h0001;
        period_d = period_q;
        stable_d = stable_q;
        acc_sum = acc_q + {11'h000, mult};
        acc_d = acc_sum;
        tick_d = 1'b0;
        if (ref_tick)
        begin
            cnt_d = 16'h0001;
            period_d = cnt_q;
            // Lock once the input period repeats within one cycle LOCK_PERIODS times running
            if ((cnt_q - period_q <= 16'h0001) || (period_q - cnt_q <= 16'h0001))
                stable_d = (stable_q == LOCK_PERIODS) ? stable_q : stable_q + 4'h1;
            else
                stable_d = 4'h0;
            acc_d = '0;
            tick_d = 1'b1; // First tick aligned to the reference edge
        end
        else if (period_q != '0 && acc_sum >= {1'b0, period_q})
        begin
            acc_d = acc_sum - {1'b0, period_q};
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            period_q <= '0;
            acc_q <= '0;
            stable_q <= 4'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            period_q <= period_d;
            acc_q <= acc_d;
            stable_q <= stable_d;
            tick_q <= tick_d;
        end
    end

    assign out_tick = tick_q;
    assign locked = (stable_q == LOCK_PERIODS);
    assign period = period_q;
endmodule

// ---- logic/sttx_frame_shift.sv ----
// Frame shifter: loads a left-aligned frame and sends it MSB first
`timescale 1ns/10ps
module sttx_frame_shift
    import sttx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bit_tick,
    input wire logic [sttx_pkg::FRAME_MAX-1:0] frame_in,
    input wire logic [4:0] frame_len,
    output logic frame_start,
    output logic first_half,
    output logic serial_out
);
    logic [FRAME_MAX-1:0] shreg_q, shreg_d;
    logic [4:0] cnt_q, cnt_d;
    logic [4:0] len_q, len_d;
    logic out_q, out_d;

    // ****************************************************************
    // Bit counter and shift register
    // ****************************************************************
    assign frame_start = bit_tick && (cnt_q == 5'h00);

    always_comb
    begin
        shreg_d = shreg_q;
        cnt_d = cnt_q;
        len_d = len_q;
        out_d = out_q;
        if (frame_start)
        begin
            out_d = frame_in[FRAME_MAX-1];
            shreg_d = {frame_in[FRAME_MAX-2:0], 1'b0};
            cnt_d = frame_len - 5'h01;
            len_d = frame_len;
        end
        else if (bit_tick)
        begin
            out_d = shreg_q[FRAME_MAX-1];
            shreg_d = {shreg_q[FRAME_MAX-2:0], 1'b0};
            cnt_d = cnt_q - 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shreg_q <= '0;
            cnt_q <= 5'h00;
            len_q <= FRAME_LEN_NARROW;
            out_q <= 1'b0;
        end
        else
        begin
            shreg_q <= shreg_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            out_q <= out_d;
        end
    end

    // High during the first half of the frame in progress
    assign first_half = (cnt_q != 5'h00) && ({cnt_q, 1'b0} >= {1'b0, len_q});
    assign serial_out = out_q;
endmodule

// ---- logic/sttx_mode_clock.sv ----
// Transmitter mode selection, frame and bit clocking, ready and reset control
//
// Behaviour
// RQ1 - A high word-width select carries 20-bit data per frame, a low one 16-bit data.
// RQ2 - In double-frame mode a half-rate input clock is multiplied up to a full frame rate.
// RQ3 - Outside double-frame mode the source supplies a parallel clock at the frame rate.
// RQ4 - Double-frame mode sends a 40- or 32-bit word as two frames per input clock period.
// RQ5 - The ready-for-payload output is the link enable retimed on the frame clock.
// RQ6 - Reset low puts every internal register into its starting state.
// RQ7 - The controller holds reset low for at least five parallel clock cycles at power-up; the bench releases presetn after two pclk cycles.
// RQ8 - With the external serial clock deselected the bit clock is the locked, multiplied input; the code takes the multiplier ticks whether or not it is locked.
// RQ9 - With the external serial clock selected the parallel clock itself is the bit clock.
// RQ10 - The frame clock output always runs at frame rate, derived from the parallel clock.
// RQ11 - With no valid word or no link enable, fill frames are sent to hold receiver lock.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
module sttx_mode_clock
    import sttx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic parallel_clock_in,
    input wire logic link_enable_from_receiver,
    input wire logic control_word_valid,
    input wire logic payload_valid,
    input wire logic [39:0] payload_in,
    output logic serial_data_out,
    output logic frame_clock_out,
    output logic ready_for_payload
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [2:0] ctrl_q, ctrl_d;
    logic word_width_select;
    logic double_frame_select;
    logic external_serial_clock_select;
    logic par_q, par_d, par_prev_q, par_prev_d;
    logic par_rise;
    logic link_en_q, link_en_d;
    logic ready_q, ready_d;
    logic half_q, half_d;
    logic [39:0] word_q, word_d;
    logic cv_q, cv_d, pv_q, pv_d;
    logic fclk_q, fclk_d;
    logic [5:0] pll_mult;
    logic pll_tick;
    logic pll_locked;
    logic [PERIOD_W-1:0] pll_period;
    logic bit_tick;
    logic frame_start;
    logic first_half;
    logic first_frame;
    logic [39:0] cur_word;
    logic cur_cv, cur_pv;
    logic [19:0] half_data;
    sttx_frame_kind_t kind;
    logic [3:0] hdr;
    logic [19:0] body;
    logic [FRAME_MAX-1:0] frame_word;
    logic [4:0] frame_len;
    logic apb_access;
    logic apb_write;
    logic mapped;
    logic [31:0] rd_mux;

    // ****************************************************************
    // APB register slave
    // ****************************************************************
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign apb_access = psel && penable;
    assign apb_write = apb_access && pwrite;
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_PERIOD);
    assign pslverr = apb_access && !mapped;

    // Read multiplexer; unmapped addresses read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (paddr == ADDR_CTRL)
            rd_mux = {29'h0000_0000, ctrl_q};
        else if (paddr == ADDR_STATUS)
        begin
            rd_mux[STAT_READY_BIT] = ready_q;
            rd_mux[STAT_LOCKED_BIT] = pll_locked;
            rd_mux[STAT_EXTCLK_BIT] = external_serial_clock_select;
        end
        else if (paddr == ADDR_PERIOD)
            rd_mux = {16'h0000, pll_period};
    end

    assign prdata = apb_access ? rd_mux : 32'h0000_0000;

    // Control register next value
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (apb_write && paddr == ADDR_CTRL)
            ctrl_d = pwdata[2:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= CTRL_RESET; // RQ6
        else
            ctrl_q <= ctrl_d;
    end

    assign word_width_select = ctrl_q[CTRL_WIDE_BIT];
    assign double_frame_select = ctrl_q[CTRL_DOUBLE_BIT];
    assign external_serial_clock_select = ctrl_q[CTRL_EXTCLK_BIT];

    // ****************************************************************
    // Input sampling
    // ****************************************************************
    // Parallel clock edge detect and link enable sample
    always_comb
    begin
        par_d = parallel_clock_in;
        par_prev_d = par_q;
        link_en_d = link_enable_from_receiver;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Both high so that a pin already high at release is not taken as an edge
            par_q <= 1'b1; // RQ6
            par_prev_q <= 1'b1;
            link_en_q <= 1'b0;
        end
        else
        begin
            par_q <= par_d;
            par_prev_q <= par_prev_d;
            link_en_q <= link_en_d;
        end
    end

    assign par_rise = par_q && !par_prev_q;

    // ****************************************************************
    // Clock generation
    // ****************************************************************
    // Bits per input period: frame length, doubled in double-frame mode
    always_comb
    begin
        frame_len = word_width_select ? FRAME_LEN_WIDE : FRAME_LEN_NARROW; // RQ1
        pll_mult = {1'b0, frame_len};
        if (double_frame_select)
            pll_mult = {frame_len, 1'b0}; // RQ2
    end

    // Multiplier locked to the parallel input clock
    sttx_rate_mult u_pll
    (
        .pclk(pclk),
        .presetn(presetn),
        .ref_tick(par_rise),
        .mult(pll_mult),
        .out_tick(pll_tick),
        .locked(pll_locked),
        .period(pll_period)
    );

    // Bit clock source: multiplied input or the input edge itself
    assign bit_tick = external_serial_clock_select ? par_rise : pll_tick; // RQ8 RQ9

    // ****************************************************************
    // Frame shifter
    // ****************************************************************
    sttx_frame_shift u_shift
    (
        .pclk(pclk),
        .presetn(presetn),
        .bit_tick(bit_tick),
        .frame_in(frame_word),
        .frame_len(frame_len),
        .frame_start(frame_start),
        .first_half(first_half),
        .serial_out(serial_data_out)
    );

    // ****************************************************************
    // Word capture and half select
    // ****************************************************************
    // A fresh word is taken for the first frame of each input period
    assign first_frame = !double_frame_select || !half_q; // RQ4
    assign cur_word = first_frame ? payload_in : word_q;
    assign cur_cv = first_frame ? control_word_valid : cv_q;
    assign cur_pv = first_frame ? payload_valid : pv_q;

    always_comb
    begin
        word_d = word_q;
        cv_d = cv_q;
        pv_d = pv_q;
        half_d = half_q;
        if (frame_start)
        begin
            if (first_frame)
            begin
                word_d = payload_in;
                cv_d = control_word_valid;
                pv_d = payload_valid;
            end
            half_d = double_frame_select && first_frame; // RQ4
        end
        else if (par_rise && !external_serial_clock_select)
            half_d = 1'b0; // Realign to the input clock edge
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            word_q <= '0; // RQ6
            cv_q <= 1'b0;
            pv_q <= 1'b0;
            half_q <= 1'b0;
        end
        else
        begin
            word_q <= word_d;
            cv_q <= cv_d;
            pv_q <= pv_d;
            half_q <= half_d;
        end
    end

    // ****************************************************************
    // Frame composition
    // ****************************************************************
    // Pick this frame's half of the user word at the selected width
    always_comb
    begin
        half_data = cur_word[19:0];
        if (word_width_select && !first_frame)
            half_data = cur_word[39:20];
        else if (!word_width_select)
            half_data = {4'h0, first_frame ? cur_word[15:0] : cur_word[31:16]}; // RQ1
    end

    // Frame kind: control wins over data; fill otherwise
    always_comb
    begin
        kind = FK_FILL;
        if (link_en_q && cur_cv)
            kind = FK_CTRL;
        else if (link_en_q && cur_pv)
            kind = FK_DATA;
    end

    always_comb
    begin
        unique case (kind)
            FK_CTRL:
            begin
                hdr = HDR_CTRL;
                body = half_data;
            end
            FK_DATA:
            begin
                hdr = HDR_DATA;
                body = half_data;
            end
            default:
            begin
                hdr = HDR_FILL; // RQ11
                body = FILL_DATA;
            end
        endcase
        frame_word = {hdr, body};
        if (!word_width_select)
            frame_word = {hdr, body[15:0], 4'h0}; // RQ1
    end

    // ****************************************************************
    // Frame clock and ready output
    // ****************************************************************
    // Frame clock high in the first half of each frame; ready retimed per frame
    always_comb
    begin
        fclk_d = first_half || frame_start; // RQ10
        ready_d = ready_q;
        if (frame_start)
            ready_d = link_en_q; // RQ5
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fclk_q <= 1'b0; // RQ6
            ready_q <= 1'b0;
        end
        else
        begin
            fclk_q <= fclk_d;
            ready_q <= ready_d;
        end
    end

    assign frame_clock_out = fclk_q;
    assign ready_for_payload = ready_q;
endmodule

// ---- testbench/sttx_chk_sva.sv ----
// Port checker for the transmitter mode and clock block
`timescale 1ns/10ps
module sttx_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic link_enable_from_receiver,
    input wire logic serial_data_out,
    input wire logic frame_clock_out,
    input wire logic ready_for_payload
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****
    // Bus answers
    // ****
    property p_rdy;
        psel && penable |-> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_bad;
        psel && penable && paddr > 12'h008 |-> pslverr && prdata == 32'h0;
    endproperty
    a_bad: assert property (p_bad) else $error("unmapped taken");
    property p_ok;
        psel && penable && paddr == 12'h000 |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("mapped refused");
    // ****
    // Link side
    // ****
    property p_rst;
        $rose(presetn) |-> !frame_clock_out && !ready_for_payload && !serial_data_out;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    property p_ren;
        (!link_enable_from_receiver)[*4] |-> !$rose(ready_for_payload);
    endproperty
    a_ren: assert property (p_ren) else $error("ready without enable");
    property p_rhold;
        link_enable_from_receiver[*4] |-> !$fell(ready_for_payload);
    endproperty
    a_rhold: assert property (p_rhold) else $error("ready lost");
    property p_fhi;
        $rose(frame_clock_out) |-> ##[1:400] !frame_clock_out;
    endproperty
    a_fhi: assert property (p_fhi) else $error("frame clock stuck high");
    property p_flo;
        $fell(frame_clock_out) |-> ##[1:400] frame_clock_out;
    endproperty
    a_flo: assert property (p_flo) else $error("frame clock stuck low");
endmodule

bind sttx_mode_clock sttx_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_enable_from_receiver(link_enable_from_receiver), .serial_data_out(serial_data_out),
    .frame_clock_out(frame_clock_out), .ready_for_payload(ready_for_payload));

// ---- testbench/sttx_far_end.sv ----
// Far-end model: user word source, word clock and link enable
`timescale 1ns/10ps
module sttx_far_end
(
    input wire logic pclk,
    input wire logic [7:0] half_per,
    input wire logic en_req,
    input wire logic [1:0] kind_req,
    input wire logic [39:0] word_req,
    output logic parallel_clock_in,
    output logic link_enable_from_receiver,
    output logic control_word_valid,
    output logic payload_valid,
    output logic [39:0] payload_in
);
    logic [7:0] cnt_q = 8'h00;
    logic clk_q = 1'b0;
    logic en_q = 1'b0;
    logic [1:0] kind_q = 2'h0;
    logic [39:0] word_q = 40'h0;
    // ****
    // Source behaviour
    // ****
    // Quiet start from the initial values; each output has one driver
    assign parallel_clock_in = clk_q;
    assign link_enable_from_receiver = en_q;
    assign {control_word_valid, payload_valid} = kind_q;
    assign payload_in = word_q;
    // Word clock; the bench sets full or half frame rate, or the bit rate with the external serial clock
    always @(posedge pclk)
    begin
        cnt_q <= (cnt_q + 8'h01 >= half_per) ? 8'h00 : cnt_q + 8'h01;
        if (cnt_q + 8'h01 >= half_per)
            clk_q <= !clk_q;
    end
    // Whole 40-bit word and valids change only at a word clock rise
    always @(posedge pclk)
    begin
        if (cnt_q + 8'h01 >= half_per && !clk_q)
        begin
            word_q <= word_req;
            kind_q <= kind_req;
            en_q <= en_req;
        end
    end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the transmitter mode and clock block
`timescale 1ns/10ps
module testbench;
    import sttx_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] half_per = 8'h28;
    logic en_req = 1'b0;
    logic [1:0] kind_req = 2'h0;
    logic [39:0] word_req = 40'h0;
    logic pci, lnk, cwv, pv, sdo, fco, rfp, rerr, fnd;
    logic [39:0] pin;
    logic [31:0] rdat;
    logic [31:0] rs = 32'h0000de03;
    logic [23:0] fr, lo, hi;
    logic [3:0] h;
    logic [19:0] msk;
    int ep[7] = '{80, 80, 40, 40, 160, 192, 160};
    int n_mismatch = 0;
    int checks = 0;

    sttx_mode_clock DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .parallel_clock_in(pci), .link_enable_from_receiver(lnk),
        .control_word_valid(cwv), .payload_valid(pv), .payload_in(pin),
        .serial_data_out(sdo), .frame_clock_out(fco), .ready_for_payload(rfp));
    sttx_far_end u_far (.pclk(pclk), .half_per(half_per), .en_req(en_req),
        .kind_req(kind_req), .word_req(word_req), .parallel_clock_in(pci),
        .link_enable_from_receiver(lnk), .control_word_valid(cwv), .payload_valid(pv),
        .payload_in(pin));

    // ****
    // Helpers
    // ****
    // Clock, 5 ns period
    initial
    begin
        forever #2.5 pclk = !pclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic near(input int a, input int b);
        return (a - b <= 2) && (b - a <= 2);
    endfunction
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_fail;
        n_mismatch++;
        final_report;
    endtask
    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20)
            wait_fail;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic fc_rise;
        int n;
        n = 0;
        while (fco !== 1'b0 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        while (fco !== 1'b1 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 2000)
            wait_fail;
    endtask
    // Samples one frame mid-bit; a bit lasts one 8-cycle word clock
    task automatic grab(output logic [23:0] f, input logic w);
        fc_rise;
        repeat (3) @(posedge pclk);
        f = 24'h0;
        for (int i = 0; i < (w ? 24 : 20); i++)
        begin
            if (i > 0)
                repeat (8) @(posedge pclk);
            f = {f[22:0], sdo};
        end
    endtask

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge pclk);
        wait_fail;
    end

    // ****
    // Scenarios
    // ****
    initial
    begin
        realtime t0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rdat, {29'h0, CTRL_RESET});
        apb(1'b0, 12'h00c, 32'h0);
        check({rerr, rdat}, {1'b1, 32'h0});
        apb(1'b1, ADDR_STATUS, 32'hffffffff);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check({rerr, rdat[STAT_EXTCLK_BIT]}, 2'h0);
        apb(1'b1, ADDR_CTRL, 32'hffffffff);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rdat, 32'h7);
        // Frame period in control settings 0 to 6; wide double-frame with the external clock (7) is not run
        for (int i = 0; i < 7; i++)
        begin
            half_per <= (i < 4) ? 8'h28 : 8'h04;
            apb(1'b1, ADDR_CTRL, 32'(i));
            rdat = 32'h0;
            for (int k = 0; k < 300 && i < 4 && rdat[STAT_LOCKED_BIT] !== 1'b1; k++)
                apb(1'b0, ADDR_STATUS, 32'h0);
            if (i < 4)
            begin
                check(rdat[STAT_LOCKED_BIT], 1'b1);
                apb(1'b0, ADDR_PERIOD, 32'h0);
                check(rdat, 32'h50);
            end
            fc_rise;
            fc_rise;
            t0 = $realtime;
            fc_rise;
            check(near(int'(($realtime - t0) / 5.0), ep[i]), 1'b1);
        end
        // Frame contents per width and kind, random words
        for (int w = 0; w < 2; w++)
        begin
            for (int j = 0; j < 4; j++)
            begin
                rs = xs(rs);
                word_req <= {rs[7:0], rs};
                kind_req <= (j == 1) ? 2'h3 : (j == 2) ? 2'h0 : 2'h1;
                en_req <= (j != 3);
                apb(1'b1, ADDR_CTRL, 32'h4 | 32'(w));
                repeat (3) grab(fr, w[0]);
                h = (j == 1) ? HDR_CTRL : (j == 0) ? HDR_DATA : HDR_FILL;
                msk = w ? 20'hfffff : 20'h0ffff;
                check(fr[(w ? 23 : 19) -: 4], h);
                check(fr[19:0] & msk, (h == HDR_FILL ? FILL_DATA : word_req[19:0]) & msk);
                check(rfp, en_req);
                apb(1'b0, ADDR_STATUS, 32'h0);
                check({rdat[STAT_EXTCLK_BIT], rdat[STAT_READY_BIT]}, {1'b1, en_req});
            end
        end
        // Double frame: low half then high half of one 40- or 32-bit word
        for (int w = 0; w < 2; w++)
        begin
            rs = xs(rs);
            word_req <= {rs[19:0] ^ 20'hfffff, rs[19:0]};
            kind_req <= 2'h1;
            en_req <= 1'b1;
            apb(1'b1, ADDR_CTRL, 32'h6 | 32'(w));
            lo = w ? {HDR_DATA, word_req[19:0]} : {4'h0, HDR_DATA, word_req[15:0]};
            hi = w ? {HDR_DATA, word_req[39:20]} : {4'h0, HDR_DATA, word_req[31:16]};
            fnd = 1'b0;
            for (int k = 0; k < 6; k++)
            begin
                grab(fr, w[0]);
                if (fnd)
                begin
                    check(fr, hi);
                    break;
                end
                fnd = (fr === lo);
            end
            check(fnd, 1'b1);
        end
        // Reset in mid-run, held five word clock periods
        half_per <= 8'h28;
        presetn <= 1'b0;
        repeat (400) @(posedge pclk);
        check({sdo, fco, rfp, pready}, 4'h1);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rdat, 32'h0);
        final_report;
    end
endmodule
